// File: inc/mcs_pkg.sv
// Contract
// - store and return lower compare limit
// - store and return upper compare limit
// - limit result codes low 0 pass 1 high 2
// - maximum mode flag write and query
// - minimum mode flag write and query
// - relative mode flag write and query
// - relative reference value write and query
// - decibel power mode flag write and query
// - impedance only from fixed ohm set
// - hold setting off hold auto-hold
// - operation condition and event read zero
// - summary set by enabled event bit
// - masks use bits 0-14, bit 15 zero
// - operation event read returns then clears
// - preset clears both enable masks
// - questionable condition read is non-destructive
// - questionable event read returns then clears
// - error query pops oldest, empty gives 0
// - version query returns fixed 1994.0
// - status bit passed only when enabled
// - raise service request as final step
// - compare mode flag write and query
// - event bit latches rising condition, sticky
package mcs_pkg;
	localparam int VW = 32;
	localparam int IW = 14;
	localparam int EW = 16;
	localparam int EQ_DEPTH = 8;
	localparam int EQ_AW = 3;
	localparam int IMP_N = 20;
	localparam logic [1:0] RES_LOW = 2'h0;
	localparam logic [1:0] RES_PASS = 2'h1;
	localparam logic [1:0] RES_HIGH = 2'h2;
	localparam logic [1:0] HOLD_OFF = 2'h0;
	localparam logic [1:0] HOLD_AUTO = 2'h2;
	localparam logic [15:0] MASK_IMPL = 16'h7fff;
	localparam int QB_FAIL_HI = 12;
	localparam int QB_FAIL_LO = 11;
	// version 1994.0 held in tenths
	localparam logic [VW-1:0] VERSION_X10 = 32'h00004de4;
	localparam logic [IW-1:0] IMP_RESET = 14'h0258;
	localparam logic [IW-1:0] IMP_SET [IMP_N] = '{
		14'h0002, 14'h0004, 14'h0008, 14'h0010, 14'h0032,
		14'h004b, 14'h005d, 14'h006e, 14'h007c, 14'h007d,
		14'h0087, 14'h0096, 14'h012c, 14'h01f4, 14'h0258,
		14'h0320, 14'h0384, 14'h03e8, 14'h04b0, 14'h1f40};

	typedef enum logic [4:0] {
		CMD_LOW_WR = 5'b00000, CMD_LOW_RD = 5'b00001,
		CMD_UPP_WR = 5'b00010, CMD_UPP_RD = 5'b00011,
		CMD_FAIL_RD = 5'b00100, CMD_MAX_WR = 5'b00101,
		CMD_MAX_RD = 5'b00110, CMD_MIN_WR = 5'b00111,
		CMD_MIN_RD = 5'b01000, CMD_REL_WR = 5'b01001,
		CMD_REL_RD = 5'b01010, CMD_RELV_WR = 5'b01011,
		CMD_RELV_RD = 5'b01100, CMD_DBM_WR = 5'b01101,
		CMD_DBM_RD = 5'b01110, CMD_IMP_WR = 5'b01111,
		CMD_IMP_RD = 5'b10000, CMD_HOLD_WR = 5'b10001,
		CMD_HOLD_RD = 5'b10010, CMD_COMP_WR = 5'b10011,
		CMD_COMP_RD = 5'b10100, CMD_OCOND_RD = 5'b10101,
		CMD_OEN_WR = 5'b10110, CMD_OEN_RD = 5'b10111,
		CMD_OEV_RD = 5'b11000, CMD_PRESET = 5'b11001,
		CMD_QCOND_RD = 5'b11010, CMD_QEN_WR = 5'b11011,
		CMD_QEN_RD = 5'b11100, CMD_QEV_RD = 5'b11101,
		CMD_ERR_RD = 5'b11110, CMD_VER_RD = 5'b11111
	} mcs_cmd_t;

	function automatic logic imp_ok(input logic [VW-1:0] v);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < IMP_N; i++) begin
			if (v == {18'h00000, IMP_SET[i]})
				hit = 1'b1;
		end
		return hit;
	endfunction
endpackage

// File: core/mcs_status_grp.sv
`timescale 1ns/100ps
module mcs_status_grp (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [15:0] cond,
	input wire logic ev_rd,
	input wire logic en_wr,
	input wire logic [15:0] en_data,
	input wire logic preset,
	output logic [15:0] event_q,
	output logic [15:0] enable_q,
	output logic summary_q
);
	logic [15:0] cond_prev_q, cond_prev_d, event_d, enable_d;
	logic summary_d;

	always_comb begin
		cond_prev_d = cond;
		// rising edge latch
		// new edges win over a read clear in the same cycle
		event_d = (ev_rd ? 16'h0000 : event_q) | (cond & ~cond_prev_q);
		enable_d = enable_q;
		if (preset)
			enable_d = 16'h0000;
		else if (en_wr)
			enable_d = en_data & mcs_pkg::MASK_IMPL;
		summary_d = |(event_q & enable_q);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cond_prev_q <= 16'h0000;
			event_q <= 16'h0000;
			enable_q <= 16'h0000;
			summary_q <= 1'b0;
		end else begin
			cond_prev_q <= cond_prev_d;
			event_q <= event_d;
			enable_q <= enable_d;
			summary_q <= summary_d;
		end
	end

	mask_top_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		enable_q[15] == 1'b0) else $error("mask bit 15 set");
	edge_latch_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cond[0] && !cond_prev_q[0]) |=> event_q[0])
		else $error("rising condition not latched");
	event_sticky_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(event_q[0] && !ev_rd) |=> event_q[0])
		else $error("event bit dropped without read");
	summary_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		|(event_q & enable_q) |=> summary_q)
		else $error("summary not raised");
endmodule // mcs_status_grp

// File: core/mcs_calc_status.sv
`timescale 1ns/100ps
module mcs_calc_status (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire mcs_pkg::mcs_cmd_t cmd_code,
	input wire logic [31:0] cmd_data,
	input wire logic rd_valid,
	input wire logic [31:0] reading,
	input wire logic [15:0] ques_cond_in,
	input wire logic err_push,
	input wire logic [15:0] err_num,
	output logic rsp_valid_q,
	output logic [31:0] rsp_data_q,
	output logic cmd_reject_q,
	output logic comp_mode_q,
	output logic [31:0] lower_lim_q,
	output logic [31:0] upper_lim_q,
	output logic [1:0] limit_result_q,
	output logic max_mode_q,
	output logic min_mode_q,
	output logic relative_offset_mode_q,
	output logic [31:0] rel_value_q,
	output logic decibel_power_mode_q,
	output logic [13:0] dbm_imp_q,
	output logic [1:0] hold_mode_q,
	output logic oper_summary_q,
	output logic ques_summary_q,
	output logic err_pending_q,
	output logic service_request_line_q
);
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic wr, rd_oev, rd_qev, oen_wr, qen_wr, preset, pop;
	logic bool_bad;
	logic [15:0] qcond, oev, oen, qev, qen;

	assign wr = cmd_valid;
	assign bool_bad = (cmd_data[31:1] != 31'h00000000);
	assign rd_oev = cmd_valid && (cmd_code == mcs_pkg::CMD_OEV_RD);
	assign rd_qev = cmd_valid && (cmd_code == mcs_pkg::CMD_QEV_RD);
	assign oen_wr = cmd_valid && (cmd_code == mcs_pkg::CMD_OEN_WR);
	assign qen_wr = cmd_valid && (cmd_code == mcs_pkg::CMD_QEN_WR);
	assign preset = cmd_valid && (cmd_code == mcs_pkg::CMD_PRESET);
	assign pop = cmd_valid && (cmd_code == mcs_pkg::CMD_ERR_RD);

	// ------------------------------------------------------------
	// status groups
	// ------------------------------------------------------------
	// no operation conditions
	mcs_status_grp u_oper (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.cond(16'h0000),
		.ev_rd(rd_oev),
		.en_wr(oen_wr),
		.en_data(cmd_data[15:0]),
		.preset(preset),
		.event_q(oev),
		.enable_q(oen),
		.summary_q(oper_summary_q)
	);

	mcs_status_grp u_ques (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.cond(qcond),
		.ev_rd(rd_qev),
		.en_wr(qen_wr),
		.en_data(cmd_data[15:0]),
		.preset(preset),
		.event_q(qev),
		.enable_q(qen),
		.summary_q(ques_summary_q)
	);

	// compare failures feed the live questionable condition
	always_comb begin
		qcond = ques_cond_in & mcs_pkg::MASK_IMPL;
		qcond[mcs_pkg::QB_FAIL_HI] = comp_mode_q
			&& (limit_result_q == mcs_pkg::RES_HIGH);
		qcond[mcs_pkg::QB_FAIL_LO] = comp_mode_q
			&& (limit_result_q == mcs_pkg::RES_LOW);
	end

	// ------------------------------------------------------------
	// error queue
	// ------------------------------------------------------------
	logic [15:0] errq_q [mcs_pkg::EQ_DEPTH];
	logic [15:0] errq_d [mcs_pkg::EQ_DEPTH];
	logic [mcs_pkg::EQ_AW:0] wp_q, wp_d, rp_q, rp_d, cnt;
	logic eq_empty, eq_full;

	assign cnt = wp_q - rp_q;
	assign eq_empty = (cnt == '0);
	assign eq_full = cnt[mcs_pkg::EQ_AW];

	// a full queue drops the newest entry, keeping the oldest history
	always_comb begin
		errq_d = errq_q;
		wp_d = wp_q;
		rp_d = rp_q;
		if (err_push && !eq_full) begin
			errq_d[wp_q[mcs_pkg::EQ_AW-1:0]] = err_num;
			wp_d = wp_q + 1'b1;
		end
		if (pop && !eq_empty)
			rp_d = rp_q + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < mcs_pkg::EQ_DEPTH; i++)
				errq_q[i] <= 16'h0000;
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			errq_q <= errq_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// ------------------------------------------------------------
	// settings, result and answers
	// ------------------------------------------------------------
	logic rsp_valid_d, cmd_reject_d, comp_mode_d, max_mode_d;
	logic min_mode_d, rel_mode_d, dbm_mode_d, err_pending_d, srq_d;
	logic [31:0] rsp_data_d, lower_lim_d, upper_lim_d, rel_value_d;
	logic [1:0] limit_result_d, hold_mode_d;
	logic [13:0] dbm_imp_d;

	always_comb begin
		rsp_valid_d = 1'b0;
		rsp_data_d = 32'h00000000;
		cmd_reject_d = 1'b0;
		comp_mode_d = comp_mode_q;
		lower_lim_d = lower_lim_q;
		upper_lim_d = upper_lim_q;
		max_mode_d = max_mode_q;
		min_mode_d = min_mode_q;
		rel_mode_d = relative_offset_mode_q;
		rel_value_d = rel_value_q;
		dbm_mode_d = decibel_power_mode_q;
		dbm_imp_d = dbm_imp_q;
		hold_mode_d = hold_mode_q;
		limit_result_d = limit_result_q;
		if (rd_valid && comp_mode_q) begin
			if ($signed(reading) < $signed(lower_lim_q))
				limit_result_d = mcs_pkg::RES_LOW;
			else if ($signed(reading) > $signed(upper_lim_q))
				limit_result_d = mcs_pkg::RES_HIGH;
			else
				limit_result_d = mcs_pkg::RES_PASS;
		end
		if (wr) begin
			case (cmd_code)
			mcs_pkg::CMD_LOW_WR: lower_lim_d = cmd_data;
			mcs_pkg::CMD_UPP_WR: upper_lim_d = cmd_data;
			mcs_pkg::CMD_COMP_WR: begin
				if (bool_bad)
					cmd_reject_d = 1'b1;
				else
					comp_mode_d = cmd_data[0];
			end
			mcs_pkg::CMD_MAX_WR: begin
				if (bool_bad)
					cmd_reject_d = 1'b1;
				else
					max_mode_d = cmd_data[0];
			end
			mcs_pkg::CMD_MIN_WR: begin
				if (bool_bad)
					cmd_reject_d = 1'b1;
				else
					min_mode_d = cmd_data[0];
			end
			mcs_pkg::CMD_REL_WR: begin
				if (bool_bad)
					cmd_reject_d = 1'b1;
				else
					rel_mode_d = cmd_data[0];
			end
			mcs_pkg::CMD_RELV_WR: rel_value_d = cmd_data;
			mcs_pkg::CMD_DBM_WR: begin
				if (bool_bad)
					cmd_reject_d = 1'b1;
				else
					dbm_mode_d = cmd_data[0];
			end
			mcs_pkg::CMD_IMP_WR: begin
				if (mcs_pkg::imp_ok(cmd_data))
					dbm_imp_d = cmd_data[13:0];
				else
					cmd_reject_d = 1'b1;
			end
			mcs_pkg::CMD_HOLD_WR: begin
				if (cmd_data > {30'h0, mcs_pkg::HOLD_AUTO})
					cmd_reject_d = 1'b1;
				else
					hold_mode_d = cmd_data[1:0];
			end
			default: ;
			endcase
			rsp_valid_d = 1'b1;
			case (cmd_code)
			mcs_pkg::CMD_LOW_RD: rsp_data_d = lower_lim_q;
			mcs_pkg::CMD_UPP_RD: rsp_data_d = upper_lim_q;
			mcs_pkg::CMD_FAIL_RD: rsp_data_d = {30'h0, limit_result_q};
			mcs_pkg::CMD_COMP_RD: rsp_data_d = {31'h0, comp_mode_q};
			mcs_pkg::CMD_MAX_RD: rsp_data_d = {31'h0, max_mode_q};
			mcs_pkg::CMD_MIN_RD: rsp_data_d = {31'h0, min_mode_q};
			mcs_pkg::CMD_REL_RD:
				rsp_data_d = {31'h0, relative_offset_mode_q};
			mcs_pkg::CMD_RELV_RD: rsp_data_d = rel_value_q;
			mcs_pkg::CMD_DBM_RD:
				rsp_data_d = {31'h0, decibel_power_mode_q};
			mcs_pkg::CMD_IMP_RD: rsp_data_d = {18'h0, dbm_imp_q};
			mcs_pkg::CMD_HOLD_RD: rsp_data_d = {30'h0, hold_mode_q};
			mcs_pkg::CMD_OCOND_RD: rsp_data_d = 32'h00000000;
			mcs_pkg::CMD_OEN_RD: rsp_data_d = {16'h0, oen};
			mcs_pkg::CMD_OEV_RD: rsp_data_d = {16'h0, oev};
			mcs_pkg::CMD_QCOND_RD: rsp_data_d = {16'h0, qcond};
			mcs_pkg::CMD_QEN_RD: rsp_data_d = {16'h0, qen};
			mcs_pkg::CMD_QEV_RD: rsp_data_d = {16'h0, qev};
			mcs_pkg::CMD_ERR_RD: begin
				if (eq_empty)
					rsp_data_d = 32'h00000000;
				else
					rsp_data_d = {{16{errq_q[rp_q[2:0]][15]}},
						errq_q[rp_q[2:0]]};
			end
			mcs_pkg::CMD_VER_RD: rsp_data_d = mcs_pkg::VERSION_X10;
			default: rsp_valid_d = 1'b0;
			endcase
		end
		err_pending_d = !eq_empty;
		srq_d = oper_summary_q || ques_summary_q;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 32'h00000000;
			cmd_reject_q <= 1'b0;
			comp_mode_q <= 1'b0;
			lower_lim_q <= 32'h00000000;
			upper_lim_q <= 32'h00000000;
			limit_result_q <= mcs_pkg::RES_PASS;
			max_mode_q <= 1'b0;
			min_mode_q <= 1'b0;
			relative_offset_mode_q <= 1'b0;
			rel_value_q <= 32'h00000000;
			decibel_power_mode_q <= 1'b0;
			dbm_imp_q <= mcs_pkg::IMP_RESET;
			hold_mode_q <= mcs_pkg::HOLD_OFF;
			err_pending_q <= 1'b0;
			service_request_line_q <= 1'b0;
		end else begin
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			cmd_reject_q <= cmd_reject_d;
			comp_mode_q <= comp_mode_d;
			lower_lim_q <= lower_lim_d;
			upper_lim_q <= upper_lim_d;
			limit_result_q <= limit_result_d;
			max_mode_q <= max_mode_d;
			min_mode_q <= min_mode_d;
			relative_offset_mode_q <= rel_mode_d;
			rel_value_q <= rel_value_d;
			decibel_power_mode_q <= dbm_mode_d;
			dbm_imp_q <= dbm_imp_d;
			hold_mode_q <= hold_mode_d;
			err_pending_q <= err_pending_d;
			service_request_line_q <= srq_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence low_wr_s;
		cmd_valid && cmd_code == mcs_pkg::CMD_LOW_WR;
	endsequence
	sequence low_rd_s;
		cmd_valid && cmd_code == mcs_pkg::CMD_LOW_RD;
	endsequence

	lower_trip_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		low_wr_s ##1 low_rd_s |=> rsp_valid_q
		&& rsp_data_q == $past(cmd_data, 2))
		else $error("lower limit not returned");
	below_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rd_valid && comp_mode_q
		&& $signed(reading) < $signed(lower_lim_q)
		|=> limit_result_q == mcs_pkg::RES_LOW)
		else $error("low result not coded 0");
	comp_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!comp_mode_q |=> $stable(limit_result_q))
		else $error("result moved with compare off");
	imp_legal_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		mcs_pkg::imp_ok({18'h0, dbm_imp_q}))
		else $error("impedance outside set");
	version_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cmd_valid && cmd_code == mcs_pkg::CMD_VER_RD
		|=> rsp_valid_q && rsp_data_q == mcs_pkg::VERSION_X10)
		else $error("wrong version answer");
	oper_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cmd_valid && cmd_code == mcs_pkg::CMD_OEV_RD
		|=> rsp_data_q == 32'h00000000)
		else $error("operation event not zero");
	preset_clr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		preset |=> oen == 16'h0000 && qen == 16'h0000)
		else $error("preset left mask bits");
	err_empty_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		pop && eq_empty |=> rsp_valid_q && rsp_data_q == 32'h0)
		else $error("empty error query not zero");
	srq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		ques_summary_q |=> service_request_line_q)
		else $error("service request missing");
	qev_clr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rd_qev && qcond == $past(qcond) |=> qev == 16'h0000)
		else $error("questionable event not cleared");
endmodule // mcs_calc_status

// File: testbench/mcs_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// instrument controller model
// ----------------------------------------
module mcs_ctrl_model (
	input wire logic ref_clk,
	input wire logic rsp_valid_q,
	input wire logic [31:0] rsp_data_q,
	output logic cmd_valid,
	output mcs_pkg::mcs_cmd_t cmd_code,
	output logic [31:0] cmd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = mcs_pkg::CMD_VER_RD;
		cmd_data = 32'h5a5a5a5a;
	end

	// launched just after an edge, held up to the taken edge
	task automatic issue(input mcs_pkg::mcs_cmd_t c, input logic [31:0] d);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_data = d;
		@(posedge ref_clk);
		#1;
	endtask

	// released lines flip so stale values never pass for fresh ones
	task automatic idle();
		cmd_valid = 1'b0;
		cmd_code = mcs_pkg::mcs_cmd_t'(~cmd_code);
		cmd_data = ~cmd_data;
		@(posedge ref_clk);
		#1;
	endtask

	// answer stands one cycle: taken right after the taken edge
	task automatic query(input mcs_pkg::mcs_cmd_t c, output logic v,
		output logic [31:0] d);
		issue(c, ~cmd_data);
		v = rsp_valid_q;
		d = rsp_data_q;
	endtask
endmodule // mcs_ctrl_model

// File: testbench/meter_calc_status_regs_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module meter_calc_status_regs_test;
	logic ref_clk, arst_n, rd_valid, err_push, cmd_valid;
	logic [31:0] reading, cmd_data, rsp_data_q;
	logic [15:0] ques_cond_in, err_num;
	mcs_pkg::mcs_cmd_t cmd_code;
	logic rsp_valid_q, cmd_reject_q, comp_mode_q, max_mode_q, min_mode_q;
	logic relative_offset_mode_q, decibel_power_mode_q, oper_summary_q;
	logic ques_summary_q, err_pending_q, service_request_line_q;
	logic [31:0] lower_lim_q, upper_lim_q, rel_value_q;
	logic [1:0] limit_result_q, hold_mode_q;
	logic [13:0] dbm_imp_q;
	logic [4:0] flags;
	int mismatches, check_count;
	mcs_pkg::mcs_cmd_t fw [5] = '{mcs_pkg::CMD_COMP_WR, mcs_pkg::CMD_MAX_WR,
		mcs_pkg::CMD_MIN_WR, mcs_pkg::CMD_REL_WR, mcs_pkg::CMD_DBM_WR};

	assign flags = {comp_mode_q, max_mode_q, min_mode_q,
		relative_offset_mode_q, decibel_power_mode_q};

	mcs_calc_status mcs_calc_status_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.rd_valid(rd_valid), .reading(reading), .ques_cond_in(ques_cond_in),
		.err_push(err_push), .err_num(err_num), .rsp_valid_q(rsp_valid_q),
		.rsp_data_q(rsp_data_q), .cmd_reject_q(cmd_reject_q),
		.comp_mode_q(comp_mode_q), .lower_lim_q(lower_lim_q),
		.upper_lim_q(upper_lim_q), .limit_result_q(limit_result_q),
		.max_mode_q(max_mode_q), .min_mode_q(min_mode_q),
		.relative_offset_mode_q(relative_offset_mode_q),
		.rel_value_q(rel_value_q), .decibel_power_mode_q(decibel_power_mode_q),
		.dbm_imp_q(dbm_imp_q), .hold_mode_q(hold_mode_q),
		.oper_summary_q(oper_summary_q), .ques_summary_q(ques_summary_q),
		.err_pending_q(err_pending_q),
		.service_request_line_q(service_request_line_q));

	mcs_ctrl_model mcs_ctrl_model_inst (.ref_clk(ref_clk),
		.rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic qry(input mcs_pkg::mcs_cmd_t c, input logic [31:0] e);
		logic v;
		logic [31:0] d;
		mcs_ctrl_model_inst.query(c, v, d);
		`CHK("rsp_valid", 1'b1, v);
		`CHK(c.name(), e, d);
	endtask

	task automatic wr(input mcs_pkg::mcs_cmd_t c, input logic [31:0] d,
		input logic rej);
		mcs_ctrl_model_inst.issue(c, d);
		`CHK("cmd_reject", rej, cmd_reject_q);
	endtask

	// read code always follows its write code
	task automatic wrb(input mcs_pkg::mcs_cmd_t c, input logic [31:0] d,
		input logic rej, input logic [31:0] e);
		wr(c, d, rej);
		qry(mcs_pkg::mcs_cmd_t'(c + 5'h1), e);
	endtask

	task automatic rdg(input int r);
		reading = r;
		rd_valid = 1'b1;
		@(posedge ref_clk);
		#1;
		rd_valid = 1'b0;
	endtask

	function automatic logic [1:0] exp_res(input int r, input int lo,
		input int hi);
		return (r < lo) ? 2'h0 : ((r > hi) ? 2'h2 : 2'h1);
	endfunction

	function automatic logic in_set(input logic [31:0] v);
		logic hit;
		hit = 1'b0;
		foreach (mcs_pkg::IMP_SET[i]) begin
			if (v === {18'h00000, mcs_pkg::IMP_SET[i]})
				hit = 1'b1;
		end
		return hit;
	endfunction

	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		stop_test();
	end

	initial begin
		int a, b, c;
		int bad[$];
		int rs[$];
		arst_n = 1'b0;
		rd_valid = 1'b0;
		reading = 32'h00000000;
		ques_cond_in = 16'h0000;
		err_push = 1'b0;
		err_num = 16'h0000;
		void'($urandom(78073));
		repeat (8) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		`CHK("limit_result", 2'h1, limit_result_q);
		`CHK("dbm_imp", 14'h0258, dbm_imp_q);
		`CHK("flags", 5'h00, flags);
		`CHK("srq", 1'b0, service_request_line_q);
		repeat (6) begin
			a = $urandom();
			b = $urandom();
			c = $urandom();
			wrb(mcs_pkg::CMD_LOW_WR, a, 1'b0, a);
			wr(mcs_pkg::CMD_UPP_WR, b, 1'b0);
			wrb(mcs_pkg::CMD_RELV_WR, c, 1'b0, c);
			qry(mcs_pkg::CMD_LOW_RD, a);
			qry(mcs_pkg::CMD_UPP_RD, b);
			`CHK("lower_lim", a, lower_lim_q);
			`CHK("upper_lim", b, upper_lim_q);
			`CHK("rel_value", c, rel_value_q);
		end
		for (int i = 0; i < 5; i++) begin
			for (int s = 1; s >= 0; s--) begin
				wrb(fw[i], s, 1'b0, s);
				`CHK(fw[i].name(), s, flags[4 - i]);
			end
			wrb(fw[i], 32'h2, 1'b1, 32'h0);
		end
		for (int h = 0; h < 4; h++)
			wrb(mcs_pkg::CMD_HOLD_WR, h, h == 3, (h == 3) ? 2 : h);
		`CHK("hold", 2'h2, hold_mode_q);
		foreach (mcs_pkg::IMP_SET[i])
			wrb(mcs_pkg::CMD_IMP_WR, mcs_pkg::IMP_SET[i], 1'b0,
				mcs_pkg::IMP_SET[i]);
		bad = '{0, 1, 601, 7999, 8001, 32'h00010258};
		repeat (6) bad.push_back($urandom_range(9000));
		foreach (bad[i])
			if (!in_set(bad[i]))
				wrb(mcs_pkg::CMD_IMP_WR, bad[i], 1'b1, 32'h1f40);
		`CHK("dbm_imp", 14'h1f40, dbm_imp_q);
		wrb(mcs_pkg::CMD_QEN_WR, 32'hffff, 1'b0, 32'h7fff);
		wrb(mcs_pkg::CMD_OEN_WR, 32'h7fff, 1'b0, 32'h7fff);
		wr(mcs_pkg::CMD_QEN_WR, 32'h0001, 1'b0);
		// masked event latches but stays unreported
		mcs_ctrl_model_inst.idle();
		ques_cond_in = 16'h0002;
		repeat (3) @(posedge ref_clk);
		#1;
		ques_cond_in = 16'h0000;
		`CHK("ques_sum", 1'b0, ques_summary_q);
		`CHK("srq", 1'b0, service_request_line_q);
		qry(mcs_pkg::CMD_QEV_RD, 32'h2);
		mcs_ctrl_model_inst.idle();
		qry(mcs_pkg::CMD_QEV_RD, 32'h0);
		mcs_ctrl_model_inst.idle();
		ques_cond_in = 16'h0001;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("ques_sum", 1'b1, ques_summary_q);
		`CHK("srq early", 1'b0, service_request_line_q);
		@(posedge ref_clk);
		#1;
		`CHK("srq", 1'b1, service_request_line_q);
		qry(mcs_pkg::CMD_QCOND_RD, 32'h1);
		qry(mcs_pkg::CMD_QCOND_RD, 32'h1);
		mcs_ctrl_model_inst.idle();
		ques_cond_in = 16'h0000;
		mcs_ctrl_model_inst.idle();
		qry(mcs_pkg::CMD_QEV_RD, 32'h1);
		mcs_ctrl_model_inst.idle();
		qry(mcs_pkg::CMD_QEV_RD, 32'h0);
		qry(mcs_pkg::CMD_OCOND_RD, 32'h0);
		qry(mcs_pkg::CMD_OEV_RD, 32'h0);
		qry(mcs_pkg::CMD_OEV_RD, 32'h0);
		`CHK("oper_sum", 1'b0, oper_summary_q);
		wr(mcs_pkg::CMD_PRESET, 32'h0, 1'b0);
		qry(mcs_pkg::CMD_OEN_RD, 32'h0);
		qry(mcs_pkg::CMD_QEN_RD, 32'h0);
		qry(mcs_pkg::CMD_VER_RD, 32'h00004de4);
		wr(mcs_pkg::CMD_LOW_WR, -100, 1'b0);
		wr(mcs_pkg::CMD_UPP_WR, 100, 1'b0);
		wr(mcs_pkg::CMD_COMP_WR, 32'h1, 1'b0);
		mcs_ctrl_model_inst.idle();
		rs = '{-101, -100, 0, 100, 101, 32'h80000000, 32'h7fffffff};
		repeat (10) rs.push_back(int'($urandom_range(600)) - 300);
		foreach (rs[i]) begin
			rdg(rs[i]);
			`CHK("limit_result", exp_res(rs[i], -100, 100),
				limit_result_q);
			qry(mcs_pkg::CMD_FAIL_RD, exp_res(rs[i], -100, 100));
		end
		// a passing reading drops both fail conditions
		mcs_ctrl_model_inst.idle();
		rdg(0);
		mcs_ctrl_model_inst.idle();
		// both fail edges were latched by the corner readings
		qry(mcs_pkg::CMD_QEV_RD, 32'h1800);
		mcs_ctrl_model_inst.idle();
		rdg(-101);
		mcs_ctrl_model_inst.idle();
		mcs_ctrl_model_inst.idle();
		qry(mcs_pkg::CMD_QEV_RD, 32'h0800);
		// error queue, newest dropped when full
		qry(mcs_pkg::CMD_ERR_RD, 32'h0);
		mcs_ctrl_model_inst.idle();
		err_push = 1'b1;
		for (int i = 0; i < 9; i++) begin
			err_num = 16'(-3 * (i + 1));
			@(posedge ref_clk);
			#1;
		end
		err_push = 1'b0;
		`CHK("err_pending", 1'b1, err_pending_q);
		for (int i = 0; i < 8; i++)
			qry(mcs_pkg::CMD_ERR_RD, -3 * (i + 1));
		qry(mcs_pkg::CMD_ERR_RD, 32'h0);
		`CHK("err_pending", 1'b0, err_pending_q);
		mcs_ctrl_model_inst.idle();
		stop_test();
	end
endmodule // meter_calc_status_regs_test
